// ### hdl/uart_sel_core.sv
// asynchronous serial channel with sleep, logic/polarity switch, collision and card mode
`timescale 1ns/10ps
`default_nettype none
module uart_sel_core (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [2:0] i_mode,
  input wire logic i_ext_sel,
  input wire logic [1:0] i_src_sel,
  input wire logic i_ext_tick,
  input wire logic [7:0] i_brg_n,
  input wire logic i_parity_en,
  input wire logic i_parity_even,
  input wire logic i_stop2,
  input wire logic i_msb_first,
  input wire logic i_logic_inv,
  input wire logic i_pol_rev,
  input wire logic i_open_drain,
  input wire logic i_sleep,
  input wire logic i_tx_end_cause,
  input wire logic i_err_sig_en,
  input wire logic i_i2c_mode,
  input wire logic i_sep_hs,
  input wire logic i_hs_func_sel,
  input wire logic i_hs_disable,
  input wire logic i_cts_n,
  input wire logic i_sep_cts_n,
  input wire logic i_tx_en,
  input wire logic i_rx_en,
  input wire logic i_tx_wr,
  input wire logic [7:0] i_tx_data,
  input wire logic i_rx_rd,
  input wire logic i_coll_clr,
  input wire logic i_err_clr,
  input wire logic i_serial_in_pin,
  output logic o_serial_out_pin,
  output logic o_serial_out_oe,
  output logic o_rts_n,
  output logic o_sep_rts_n,
  output logic o_ch1_hs_block,
  output logic o_tx_buf_empty,
  output logic o_rx_full,
  output logic [7:0] o_rx_data,
  output logic o_overrun,
  output logic o_framing_err,
  output logic o_parity_err,
  output logic o_err_sum,
  output logic o_tx_irq,
  output logic o_rx_irq,
  output logic o_coll_irq,
  output logic o_coll_req
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    uart_sel_pkg::tx_state_t txs;
    uart_sel_pkg::rx_state_t rxs;
    logic [7:0] tbuf;
    logic tbuf_empty;
    logic [7:0] tsh;
    logic [3:0] tcnt;
    logic tpar;
    logic tline;
    logic [3:0] rph;
    logic [7:0] rsh;
    logic [3:0] rcnt;
    logic rpar;
    logic rperr;
    logic [7:0] rbuf;
    logic rfull;
    logic ovr;
    logic fer;
    logic per;
    logic sum;
    logic coll;
    logic errdrv;
    logic txirq;
    logic rxirq;
    logic collirq;
    logic rx_prev;
    logic [7:0] rdat;
  } core_st_t;
  core_st_t st;
  core_st_t next_st;
  logic os_tick;
  logic bit_tick;
  logic rx_lvl;
  logic cts_ok;
  logic [7:0] rx_byte;
  logic rx_sample;
  logic stop_ok;

  function automatic logic [7:0] bit_rev(input logic [7:0] d);
    logic [7:0] r;
    r = '0;
    for (int k = 0; k < 8; k++) begin
      r[k] = d[7-k];
    end
    return r;
  endfunction : bit_rev

  function automatic logic odd_ones(input logic [7:0] d);
    return ^d;
  endfunction : odd_ones

  ////////////////////////////////////////////////////////////////////////////
  uart_sel_bitrate u_brg (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ext_sel(i_ext_sel),
    .i_src_sel(i_src_sel),
    .i_ext_tick(i_ext_tick),
    .i_brg_n(i_brg_n),
    .o_os_tick(os_tick),
    .o_bit_tick(bit_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // separate handshake moves cts/rts to distinct pins
  assign cts_ok = i_hs_disable || i_hs_func_sel || (i_sep_hs ? !i_sep_cts_n : !i_cts_n);
  assign o_ch1_hs_block = i_sep_hs;
  assign o_rts_n = i_sep_hs ? 1'b1 : !(i_rx_en && !st.rfull && !i_hs_disable && i_hs_func_sel);
  assign o_sep_rts_n = i_sep_hs ? !(i_rx_en && !st.rfull) : 1'b1;
  assign rx_lvl = i_serial_in_pin ^ i_pol_rev;
  assign o_serial_out_pin = st.tline ^ i_pol_rev;
  // open drain: release the line whenever the transmit level before polarity reversal is high
  assign o_serial_out_oe = i_open_drain ? (st.tline == 1'b0) : 1'b1;
  assign o_tx_buf_empty = st.tbuf_empty;
  assign o_rx_full = st.rfull;
  assign o_rx_data = st.rdat;
  assign o_overrun = st.ovr;
  assign o_framing_err = st.fer;
  assign o_parity_err = st.per;
  assign o_err_sum = st.sum;
  assign o_tx_irq = st.txirq;
  assign o_rx_irq = st.rxirq;
  assign o_coll_irq = st.collirq;
  assign o_coll_req = st.coll;
  assign rx_sample = os_tick && (st.rph == uart_sel_pkg::OVS_MID);
  // msb-first reception is mirrored back into data order
  assign rx_byte = i_msb_first ? bit_rev(st.rsh) : st.rsh;
  assign stop_ok = rx_lvl;
  localparam logic [3:0] DATA_BITS_P1 = uart_sel_pkg::DATA_BITS + 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.txirq = 1'b0;
    next_st.rxirq = 1'b0;
    next_st.collirq = 1'b0;
    next_st.rx_prev = rx_lvl;
    // buffer reads are inverted when the data logic switch is on
    next_st.rdat = i_logic_inv ? ~st.rbuf : st.rbuf;
    if (i_rx_rd) begin
      next_st.rfull = 1'b0;
    end
    if (i_err_clr) begin
      next_st.ovr = 1'b0;
      next_st.fer = 1'b0;
      next_st.per = 1'b0;
      next_st.sum = 1'b0;
    end
    if (i_coll_clr) begin
      next_st.coll = 1'b0;
    end
    if (i_tx_wr) begin
      next_st.tbuf = i_logic_inv ? ~i_tx_data : i_tx_data;
      next_st.tbuf_empty = 1'b0;
    end
    // transmitter
    unique case (st.txs)
      uart_sel_pkg::TX_IDLE: begin
        next_st.tline = !st.errdrv;
        if (bit_tick && i_tx_en && !st.tbuf_empty && cts_ok) begin
          next_st.tsh = i_msb_first ? bit_rev(st.tbuf) : st.tbuf;
          next_st.tpar = odd_ones(st.tbuf) ^ !i_parity_even;
          next_st.tbuf_empty = 1'b0;
          next_st.tbuf_empty = i_tx_wr ? 1'b0 : 1'b1;
          next_st.tline = 1'b0;
          next_st.tcnt = '0;
          next_st.txs = uart_sel_pkg::TX_START;
          if (!i_tx_end_cause) begin
            next_st.txirq = !i_i2c_mode;
          end
        end
      end
      uart_sel_pkg::TX_START: begin
        if (bit_tick) begin
          next_st.tline = st.tsh[0];
          next_st.tsh = {1'b0, st.tsh[7:1]};
          next_st.tcnt = 4'h1;
          next_st.txs = uart_sel_pkg::TX_DATA;
        end
      end
      uart_sel_pkg::TX_DATA: begin
        if (bit_tick) begin
          if (st.tcnt == uart_sel_pkg::DATA_BITS) begin
            next_st.tline = i_parity_en ? st.tpar : 1'b1;
            next_st.tcnt = '0;
            next_st.txs = i_parity_en ? uart_sel_pkg::TX_PAR : uart_sel_pkg::TX_STOP;
          end else begin
            next_st.tline = st.tsh[0];
            next_st.tsh = {1'b0, st.tsh[7:1]};
            next_st.tcnt = st.tcnt + 4'h1;
          end
        end
      end
      uart_sel_pkg::TX_PAR: begin
        if (bit_tick) begin
          next_st.tline = 1'b1;
          next_st.txs = uart_sel_pkg::TX_STOP;
        end
      end
      uart_sel_pkg::TX_STOP: begin
        if (bit_tick) begin
          if (i_stop2 && st.tcnt == 4'h0) begin
            next_st.tcnt = 4'h1;
          end else begin
            next_st.txs = uart_sel_pkg::TX_IDLE;
            // with the error signal on, completion waits for the card's error slot
            if (i_tx_end_cause && !i_err_sig_en) begin
              next_st.txirq = !i_i2c_mode;
            end
          end
        end
        // card reports parity error during our stop bit; the cpu samples the input then
        if (i_err_sig_en && i_tx_end_cause && rx_sample && st.tcnt == 4'h0) begin
          next_st.txirq = !i_i2c_mode;
        end
      end
      default: next_st.txs = uart_sel_pkg::TX_IDLE;
    endcase
    // bus collision sampled on each transfer clock rise
    if (bit_tick && (st.tline != rx_lvl) && !i_i2c_mode) begin
      next_st.coll = 1'b1;
      next_st.collirq = 1'b1;
    end
    // i2c: start/stop conditions replace the collision cause
    if (i_i2c_mode && rx_lvl != st.rx_prev) begin
      next_st.collirq = 1'b1;
    end
    // receiver
    if (os_tick) begin
      next_st.rph = st.rph + 4'h1;
    end
    unique case (st.rxs)
      uart_sel_pkg::RX_IDLE: begin
        if (i_rx_en && st.rx_prev && !rx_lvl) begin
          next_st.rph = '0;
          next_st.rxs = uart_sel_pkg::RX_START;
        end
      end
      uart_sel_pkg::RX_START: begin
        if (rx_sample) begin
          next_st.rcnt = '0;
          next_st.rpar = 1'b0;
          next_st.rxs = rx_lvl ? uart_sel_pkg::RX_IDLE : uart_sel_pkg::RX_DATA;
        end
      end
      uart_sel_pkg::RX_DATA: begin
        if (rx_sample) begin
          next_st.rsh = {rx_lvl, st.rsh[7:1]};
          next_st.rpar = st.rpar ^ rx_lvl;
          next_st.rcnt = st.rcnt + 4'h1;
          if (st.rcnt == uart_sel_pkg::DATA_BITS - 4'h1) begin
            next_st.rxs = i_parity_en ? uart_sel_pkg::RX_PAR : uart_sel_pkg::RX_STOP;
            next_st.rcnt = '0;
          end
        end
      end
      uart_sel_pkg::RX_PAR: begin
        if (rx_sample) begin
          next_st.rperr = (st.rpar ^ rx_lvl) != !i_parity_even;
          next_st.rxs = uart_sel_pkg::RX_STOP;
        end
      end
      uart_sel_pkg::RX_STOP: begin
        if (rx_sample) begin
          // hold error low through the stop slot, released on the next
          next_st.errdrv = i_err_sig_en && i_parity_en && st.rperr && st.rcnt == 4'h0;
          if (i_stop2 && st.rcnt == 4'h0 && stop_ok) begin
            next_st.rcnt = 4'h1;
          end else begin
            next_st.rxs = uart_sel_pkg::RX_IDLE;
            if (!(i_sleep && !rx_byte[7])) begin
              next_st.rbuf = rx_byte;
              next_st.rfull = 1'b1;
              next_st.fer = !stop_ok;
              next_st.per = i_parity_en && st.rperr;
              next_st.ovr = st.rfull && !i_rx_rd;
              next_st.rxirq = !(st.rfull && !i_rx_rd) && !i_i2c_mode;
              next_st.sum = !stop_ok || (i_parity_en && st.rperr) || (st.rfull && !i_rx_rd)
                || st.sum;
            end
          end
        end
      end
      default: next_st.rxs = uart_sel_pkg::RX_IDLE;
    endcase
    if (st.errdrv && rx_sample && st.rxs == uart_sel_pkg::RX_IDLE) begin
      next_st.errdrv = 1'b0;
    end
    if (st.errdrv && st.txs == uart_sel_pkg::TX_IDLE) begin
      next_st.tline = 1'b0;
    end
    if (i_i2c_mode && bit_tick && st.tcnt == DATA_BITS_P1) begin
      next_st.txirq = rx_lvl;
      next_st.rxirq = !rx_lvl;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st <= '{txs: uart_sel_pkg::TX_IDLE, rxs: uart_sel_pkg::RX_IDLE,
              tbuf_empty: 1'b1, tline: 1'b1, rx_prev: 1'b1,
              tbuf: uart_sel_pkg::RESET_BYTE, rbuf: uart_sel_pkg::RESET_BYTE, default: '0};
    end else begin
      st <= next_st;
    end
  end
endmodule : uart_sel_core
`default_nettype wire

// ### hdl/uart_sel_pkg.sv
// constants for the asynchronous serial channel with select functions
package uart_sel_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [1:0] SRC_F1 = 2'h0;
  localparam logic [1:0] SRC_F8 = 2'h1;
  localparam logic [1:0] SRC_F32 = 2'h2;
  localparam logic [4:0] PRE_F8_LAST = 5'h07;
  localparam logic [4:0] PRE_F32_LAST = 5'h1f;
  localparam logic [2:0] MODE_UART8 = 3'h5;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] DATA_BITS = 4'h8;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PAR = 5'b01000,
    TX_STOP = 5'b10000
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_PAR = 5'b01000,
    RX_STOP = 5'b10000
  } rx_state_t;
endpackage : uart_sel_pkg

// ### hdl/uart_sel_bitrate.sv
// bit-rate generator: selected count source divided by (n+1), then by 16
`timescale 1ns/10ps
`default_nettype none
module uart_sel_bitrate (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ext_sel,
  input wire logic [1:0] i_src_sel,
  input wire logic i_ext_tick,
  input wire logic [7:0] i_brg_n,
  output logic o_os_tick,
  output logic o_bit_tick
);
  typedef struct packed {
    logic [4:0] pre;
    logic [7:0] brg;
    logic [3:0] ovs;
  } brg_st_t;
  brg_st_t st;
  brg_st_t next_st;
  logic src_tick;
  always_comb begin
    next_st = st;
    o_os_tick = 1'b0;
    src_tick = 1'b0;
    next_st.pre = st.pre + 5'h01;
    unique case (i_src_sel)
      uart_sel_pkg::SRC_F8: src_tick = (st.pre[2:0] == uart_sel_pkg::PRE_F8_LAST[2:0]);
      uart_sel_pkg::SRC_F32: src_tick = (st.pre == uart_sel_pkg::PRE_F32_LAST);
      default: src_tick = 1'b1;
    endcase
    if (i_ext_sel) begin
      src_tick = i_ext_tick;
    end
    if (src_tick) begin
      if (st.brg >= i_brg_n) begin
        next_st.brg = 8'h00;
        o_os_tick = 1'b1;
      end else begin
        next_st.brg = st.brg + 8'h01;
      end
    end
    if (o_os_tick) begin
      next_st.ovs = st.ovs + 4'h1;
    end
    o_bit_tick = o_os_tick && (st.ovs == uart_sel_pkg::OVS_LAST);
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : uart_sel_bitrate
`default_nettype wire

// ### bench/uart_sel_peer.sv
// far-side serial peer: frame sender and capturer on a pulled-up line
`timescale 1ns/10ps
`default_nettype none
module uart_sel_peer (
  input wire logic i_clk_sys,
  input wire logic i_line,
  output logic o_line
);
  int bit_cyc = 16;
  // released line idles high through the pull-up
  initial o_line = 1'b1;
  ////////////////////////////////////////////////////////////////////////////////
  // frame bits go out in index order: start, 8 data, parity, one stop
  task automatic send(input logic [10:0] f);
    for (int i = 0; i < 11; i++) begin
      @(negedge i_clk_sys);
      o_line = f[i];
      repeat (bit_cyc - 1) @(negedge i_clk_sys);
    end
    @(negedge i_clk_sys);
    o_line = 1'b1;
  endtask : send
  // mid-bit sampling keeps clear of the edge where the output register moves
  task automatic grab(output logic [10:0] f);
    @(negedge i_line);
    repeat (bit_cyc / 2) @(posedge i_clk_sys);
    for (int i = 0; i < 11; i++) begin
      f[i] = i_line;
      repeat (bit_cyc) @(posedge i_clk_sys);
    end
    // hand control back on the falling edge, where the bench drives
    @(negedge i_clk_sys);
  endtask : grab
endmodule : uart_sel_peer
`default_nettype wire

// ### bench/uart_sel_core_monitor.sv
// port checker for the serial channel core
`timescale 1ns/10ps
`default_nettype none
module uart_sel_core_monitor (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_pol_rev,
  input wire logic i_sep_hs,
  input wire logic i_tx_wr,
  input wire logic i_tx_en,
  input wire logic i_rx_en,
  input wire logic i_coll_clr,
  input wire logic o_serial_out_pin,
  input wire logic o_ch1_hs_block,
  input wire logic o_tx_buf_empty,
  input wire logic o_rx_full,
  input wire logic o_overrun,
  input wire logic o_framing_err,
  input wire logic o_parity_err,
  input wire logic o_err_sum,
  input wire logic o_rx_irq,
  input wire logic o_coll_req
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_reset_idle: assert property (disable iff (1'b0) i_rst |->
    o_tx_buf_empty && !o_rx_full && !o_err_sum && o_serial_out_pin == !i_pol_rev)
    else $error("reset state wrong");
  a_buf_load: assert property (i_tx_wr |=> !o_tx_buf_empty)
    else $error("write did not fill buffer");
  a_tx_hold: assert property (!i_tx_en && !o_tx_buf_empty |=> !o_tx_buf_empty)
    else $error("buffer moved while disabled");
  a_rx_enable: assert property ($rose(o_rx_full) |-> $past(i_rx_en))
    else $error("receive while disabled");
  a_rx_irq_full: assert property (o_rx_irq |-> ##[0:1] o_rx_full)
    else $error("receive request without data");
  a_overrun_quiet: assert property ($rose(o_overrun) |-> !o_rx_irq)
    else $error("receive request on overrun");
  a_err_sum: assert property ((o_overrun || o_framing_err || o_parity_err) |->
    ##[0:1] o_err_sum)
    else $error("error sum missing");
  a_coll_sticky: assert property ($past(o_coll_req) && !$past(i_coll_clr) |-> o_coll_req)
    else $error("collision request dropped");
  a_ch1_block: assert property (o_ch1_hs_block == i_sep_hs)
    else $error("second handshake not blocked");
endmodule : uart_sel_core_monitor
bind uart_sel_core uart_sel_core_monitor mon (.*);
`default_nettype wire

// ### bench/uart_sel_core_tb_top.sv
// testbench for the serial channel core
`timescale 1ns/10ps
`default_nettype none
module uart_sel_core_tb_top;
  logic i_clk_sys, i_rst, i_ext_sel, i_parity_en, i_parity_even, i_stop2, i_msb_first;
  logic i_logic_inv, i_pol_rev, i_open_drain, i_sleep, i_err_sig_en, i_sep_hs, i_tx_end_cause;
  logic i_hs_disable, i_cts_n, i_tx_en, i_rx_en, i_tx_wr, i_rx_rd, i_coll_clr, i_err_clr;
  logic line_in, o_serial_out_pin, o_serial_out_oe, o_ch1_hs_block, o_tx_buf_empty;
  logic o_rx_full, o_overrun, o_framing_err, o_parity_err, o_err_sum, o_rx_irq, o_coll_req;
  logic [1:0] i_src_sel;
  logic [7:0] i_brg_n, i_tx_data, o_rx_data;
  logic [10:0] cap;
  int error_cnt = 0, check_count = 0, rx_irqs = 0, cyc = 0, low_seen = 0, n, e;
  int tx_irqs = 0, coll_irqs = 0, m;
  logic o_tx_irq, o_coll_irq, o_rts_n, o_sep_rts_n, irq_line;
  // i2c stays off for asynchronous use
  uart_sel_core dut (.*, .i_mode(uart_sel_pkg::MODE_UART8), .i_i2c_mode(1'b0),
    .i_hs_func_sel(1'b0), .i_sep_cts_n(1'b0), .i_ext_tick(1'b0),
    .i_serial_in_pin(line_in));
  uart_sel_peer peer (.i_clk_sys(i_clk_sys), .i_line(o_serial_out_pin), .o_line(line_in));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  // ceiling well above the few thousand cycles the tests need
  always @(posedge i_clk_sys) begin
    cyc++;
    if (o_rx_irq === 1'b1) rx_irqs++;
    if (o_coll_irq === 1'b1) coll_irqs++;
    // line level as seen when the transmit request fires
    if (o_tx_irq === 1'b1) begin
      tx_irqs++;
      irq_line = line_in;
    end
    if (o_serial_out_oe === 1'b1 && o_serial_out_pin === 1'b0) low_seen++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    @(negedge i_clk_sys);
    s = 1'b1;
    @(negedge i_clk_sys);
    s = 1'b0;
  endtask : pulse
  task automatic rx(input logic [7:0] b, input logic p, input logic s);
    peer.send({s, p, b, 1'b0});
    repeat (20) @(negedge i_clk_sys);
  endtask : rx
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_rst = 1'b1;
    {i_ext_sel, i_stop2, i_msb_first, i_logic_inv, i_pol_rev, i_open_drain} = 6'h00;
    {i_sleep, i_err_sig_en, i_sep_hs, i_cts_n, i_tx_wr, i_rx_rd} = 6'h00;
    {i_coll_clr, i_err_clr, i_src_sel, i_brg_n, i_tx_data} = 20'h00000;
    {i_parity_en, i_parity_even, i_hs_disable, i_tx_end_cause} = 4'hf;
    {i_tx_en, i_rx_en} = 2'h0;
    repeat (20) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_rst = 1'b0;
    chk("idle", {o_serial_out_pin, o_serial_out_oe, o_tx_buf_empty, o_err_sum}, 11'he);
    i_tx_data = 8'ha5;
    pulse(i_tx_wr);
    repeat (40) @(negedge i_clk_sys);
    chk("tx held", {o_serial_out_pin, o_tx_buf_empty}, 11'h2);
    fork peer.grab(cap); i_tx_en = 1'b1; join
    chk("tx direct", cap, {1'b1, ^8'ha5, 8'ha5, 1'b0});
    chk("tx irq", tx_irqs, 1);
    $display("test direct done");
    {i_msb_first, i_logic_inv, i_parity_even, i_rx_en} = 4'hd;
    i_tx_data = 8'h3b;
    fork peer.grab(cap); pulse(i_tx_wr); join
    chk("tx inverse", cap, {1'b1, ~^8'hc4, 8'h23, 1'b0});
    rx(8'h23, 1'b0, 1'b1);
    chk("rx inverse", o_rx_data, 8'h3b);
    pulse(i_rx_rd);
    {i_msb_first, i_logic_inv, i_parity_even} = 3'h1;
    $display("test inverse done");
    n = rx_irqs;
    rx(8'h5c, ^8'h5c, 1'b1);
    chk("rx data", {o_rx_full, o_rx_data}, {1'b1, 8'h5c});
    chk("rx irq", rx_irqs - n, 1);
    pulse(i_rx_rd);
    i_sleep = 1'b1;
    rx(8'h12, ^8'h12, 1'b1);
    chk("sleep drop", o_rx_full, 0);
    rx(8'h92, ^8'h92, 1'b1);
    chk("sleep keep", {o_rx_full, o_rx_data}, {1'b1, 8'h92});
    pulse(i_rx_rd);
    i_sleep = 1'b0;
    $display("test receive done");
    n = rx_irqs;
    rx(8'h11, ^8'h11, 1'b1);
    rx(8'h22, ^8'h22, 1'b1);
    chk("overrun", {o_overrun, o_err_sum, o_rx_data}, {2'h3, 8'h22});
    chk("overrun irq", rx_irqs - n, 1);
    pulse(i_err_clr);
    pulse(i_rx_rd);
    i_err_sig_en = 1'b1;
    low_seen = 0;
    rx(8'h5c, ~^8'h5c, 1'b1);
    chk("parity sig", {o_parity_err, low_seen != 0}, 11'h3);
    chk("sig released", o_serial_out_pin, 1);
    pulse(i_err_clr);
    pulse(i_rx_rd);
    i_err_sig_en = 1'b0;
    rx(8'h5c, ^8'h5c, 1'b0);
    chk("framing", o_framing_err, 1);
    pulse(i_err_clr);
    pulse(i_rx_rd);
    $display("test errors done");
    // receiver off, else the held-low line is taken in as one character with a framing error
    i_rx_en = 1'b0;
    pulse(i_coll_clr);
    chk("coll idle", o_coll_req, 0);
    n = coll_irqs;
    peer.o_line = 1'b0;
    i_tx_data = 8'hff;
    pulse(i_tx_wr);
    repeat (220) @(negedge i_clk_sys);
    peer.o_line = 1'b1;
    repeat (30) @(negedge i_clk_sys);
    chk("collision", o_coll_req, 1);
    chk("coll irq", coll_irqs != n, 1);
    pulse(i_coll_clr);
    chk("coll clear", o_coll_req, 0);
    // card answers with a low error slot over our stop bit
    i_err_sig_en = 1'b1;
    m = tx_irqs;
    fork
      begin
        @(negedge o_serial_out_pin);
        repeat (160) @(negedge i_clk_sys);
        peer.o_line = 1'b0;
        repeat (18) @(negedge i_clk_sys);
        peer.o_line = 1'b1;
      end
      pulse(i_tx_wr);
    join
    chk("card error", {tx_irqs == m + 1, irq_line}, 11'h2);
    i_err_sig_en = 1'b0;
    $display("test collision done");
    i_parity_en = 1'b0;
    for (int k = 0; k < 2; k++) begin
      i_brg_n = k ? 8'h00 : 8'h02;
      i_src_sel = k ? uart_sel_pkg::SRC_F8 : uart_sel_pkg::SRC_F1;
      e = uart_sel_pkg::OVERSAMPLE * (k ? 8 : 3);
      fork
        begin
          @(negedge o_serial_out_pin);
          n = 0;
          @(negedge i_clk_sys);
          while (o_serial_out_pin === 1'b0) begin
            n++;
            @(negedge i_clk_sys);
          end
        end
        pulse(i_tx_wr);
      join
      chk("bit time", n, e);
      repeat (e * 10) @(negedge i_clk_sys);
    end
    $display("test rate done");
    i_pol_rev = 1'b1;
    i_hs_disable = 1'b0;
    i_sep_hs = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    chk("reversed idle", o_serial_out_pin, 0);
    {i_pol_rev, i_rx_en} = 2'h1;
    repeat (3) @(negedge i_clk_sys);
    chk("sep handshake", {o_ch1_hs_block, o_rts_n, o_sep_rts_n}, 11'h6);
    {i_pol_rev, i_sep_hs, i_open_drain} = 3'h1;
    repeat (3) @(negedge i_clk_sys);
    chk("drain idle", o_serial_out_oe, 0);
    $display("test idle done");
    stop_test();
  end
endmodule : uart_sel_core_tb_top
`default_nettype wire
